// *** dv/mgmt_host_model.sv ***
`timescale 1ns/100ps
module mgmt_host_model (
  input wire logic sys_clk,
  output phy_mode_pkg::bus_addr_t awaddr,
  output logic awvalid,
  input wire logic awready,
  output phy_mode_pkg::bus_data_t wdata,
  output phy_mode_pkg::bus_strb_t wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire phy_mode_pkg::bus_resp_t bresp,
  input wire logic bvalid,
  output logic bready,
  output phy_mode_pkg::bus_addr_t araddr,
  output logic arvalid,
  input wire logic arready,
  input wire phy_mode_pkg::bus_data_t rdata,
  input wire phy_mode_pkg::bus_resp_t rresp,
  input wire logic rvalid,
  output logic rready,
  output logic hung
);
  import phy_mode_pkg::*;
  // ****************************************************************
  // Register bus master
  // ****************************************************************
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready, hung} = '0;
  end

  task automatic wr(input bus_addr_t a, input bus_data_t d, output bus_resp_t r);
    int n;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= (a == 8'h60) ? (d & 32'h0000_F5FD) : d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 40) hung <= 1'b1;
  endtask

  task automatic rd(input bus_addr_t a, output bus_data_t d, output bus_resp_t r);
    int n;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 40) hung <= 1'b1;
  endtask
endmodule // mgmt_host_model

// *** dv/phy_mode_ctrl_checker.sv ***
`timescale 1ns/100ps
module phy_mode_ctrl_checker
  import phy_mode_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire phy_mode_pkg::bus_data_t rdata,
  input wire phy_mode_pkg::bus_resp_t rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic rx_activity,
  input wire logic far_fault_pattern_seen,
  input wire logic activity_indication,
  input wire logic far_fault_detected,
  input wire logic irq
);
  // ****************************************************************
  // Bus handshake and status relations
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ar_answer_a: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
  r_release_a: assert property (rvalid && rready |=> !rvalid) else $error("read data not released");
  b_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  b_release_a: assert property (bvalid && bready |=> !bvalid) else $error("write response not released");
  ar_block_a: assert property (rvalid |-> !arready) else $error("read accepted while busy");
  aw_block_a: assert property (bvalid |-> !awready && !wready) else $error("write accepted while busy");
  upper_zero_a: assert property (rvalid |-> rdata[31:16] == 16'h0000) else $error("upper half not zero");
  // Refused reads carry no data
  slverr_zero_a: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
    else $error("error read carries data");
  rx_activity_a: assert property (rx_activity [*4] |-> activity_indication) else $error("activity missed");
  fault_quiet_a: assert property (!far_fault_pattern_seen [*4] |-> !far_fault_detected)
    else $error("fault seen without pattern");

  cover property (rvalid && rresp == RESP_SLVERR);
  cover property (bvalid && bready);
  cover property ($rose(irq));
endmodule // phy_mode_ctrl_checker

bind phy_mode_ctrl phy_mode_ctrl_checker chk_i (.sys_clk, .rst_n, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rx_activity,
  .far_fault_pattern_seen, .activity_indication, .far_fault_detected, .irq);

// *** dv/phy_mode_ctrl_rx_err_count_test.sv ***
`timescale 1ns/100ps
module phy_mode_ctrl_rx_err_count_test;
  import phy_mode_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_error_event = 1'b0;
  logic fiber_n = 1'b1;
  logic scram = 1'b1;
  logic [6:0] misc = 7'h00;
  bus_addr_t awaddr, araddr;
  bus_data_t wdata, rdata, d;
  bus_strb_t wstrb;
  bus_resp_t bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, hung, irq;
  logic signal_detect_common_mode_select, link_up_10, link_up_100, jabber_protect_enable;
  logic activity_indication, far_fault_transmit, far_fault_detected, decoder_watchdog_disable;
  logic remote_loopback_enable, scramble_enable, fiber_mode_select;
  int bad_count = 0;
  int checked = 0;
  int seed = 32'h0fd7_a5a6;
  int mode_m, i;
  wire [10:0] outs = {signal_detect_common_mode_select, link_up_10, link_up_100, jabber_protect_enable,
    activity_indication, far_fault_transmit, far_fault_detected, decoder_watchdog_disable,
    remote_loopback_enable, scramble_enable, fiber_mode_select};

  always #20 sys_clk = ~sys_clk;

  phy_mode_ctrl DUT (.sys_clk, .rst_n, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .rx_error_event, .fiber_strap_pin_n(fiber_n), .scramble_strap_pin(scram), .repeater_mode(misc[6]),
    .nlp_link_ok(misc[5]), .link_ok_100(misc[4]), .local_fault_detected(misc[3]),
    .far_fault_pattern_seen(misc[2]), .rx_activity(misc[1]), .tx_activity(misc[0]),
    .signal_detect_common_mode_select, .link_up_10, .link_up_100, .jabber_protect_enable,
    .activity_indication, .far_fault_transmit, .far_fault_detected, .decoder_watchdog_disable,
    .remote_loopback_enable, .scramble_enable, .fiber_mode_select, .irq);

  mgmt_host_model host (.sys_clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .hung);

  // ****************************************************************
  // Reference model and checks
  // ****************************************************************
  function automatic logic [10:0] outs_exp(input int m, input logic [6:0] v);
    return {m[15], m[14] | v[5], m[13] | v[4], !m[12], v[1] | (v[0] & !(m[10] & !v[6])),
      m[7] | (!m[8] & v[3]), !m[8] & v[2], m[4], m[3], m[2], m[0]};
  endfunction

  task automatic chk(input bus_data_t got, input bus_data_t exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input bus_addr_t a, input bus_data_t e, input bus_resp_t er);
    bus_data_t x;
    bus_resp_t r;
    host.rd(a, x, r);
    chk(x, e);
    chk(32'(r), 32'(er));
  endtask

  task automatic wchk(input bus_addr_t a, input bus_data_t v, input bus_resp_t er);
    bus_resp_t r;
    host.wr(a, v, r);
    chk(32'(r), 32'(er));
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic err_pulse(input int n);
    repeat (n) begin
      rx_error_event <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rx_error_event <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask

  // Straps settle through the synchroniser while reset is held
  task automatic restart(input logic fn, input logic sc);
    fiber_n <= fn;
    scram <= sc;
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge hung) begin
    bad_count++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    // Strap defaults after reset
    rchk(8'h60, 32'h0000_0504, RESP_OKAY);
    rchk(8'h54, 32'h0, RESP_OKAY);
    for (i = 0; i < 10; i++) begin
      d = (i == 0) ? 32'h0000_FFFF : (i == 1) ? 32'h0 : $random(seed);
      misc <= 7'($random(seed));
      wchk(8'h60, d, RESP_OKAY);
      mode_m = (d & 32'h0000_F5BD) | (d[0] ? 4 : 0);
      repeat (4) @(posedge sys_clk);
      rchk(8'h60, mode_m, RESP_OKAY);
      chk(outs, outs_exp(mode_m, misc));
    end
    // Counting, then disabled counting
    wchk(8'h60, 32'h0000_0400, RESP_OKAY);
    err_pulse(3);
    rchk(8'h54, 32'h3, RESP_OKAY);
    rchk(8'h68, 32'h2, RESP_OKAY);
    wchk(8'h6C, 32'h3, RESP_OKAY);
    chk(irq, 1'b1);
    wchk(8'h68, 32'h3, RESP_OKAY);
    chk(irq, 1'b0);
    wchk(8'h60, 32'h0000_0420, RESP_OKAY);
    err_pulse(2);
    rchk(8'h54, 32'h3, RESP_OKAY);
    // Saturation and full flag
    wchk(8'h60, 32'h0000_0400, RESP_OKAY);
    wchk(8'h54, 32'h0000_FFFE, RESP_OKAY);
    rchk(8'h54, 32'h0000_FFFE, RESP_OKAY);
    err_pulse(2);
    rchk(8'h54, 32'h0000_FFFF, RESP_OKAY);
    rchk(8'h60, 32'h0000_0440, RESP_OKAY);
    chk(irq, 1'b1);
    wchk(8'h54, 32'h0, RESP_OKAY);
    wchk(8'h68, 32'h3, RESP_OKAY);
    chk(irq, 1'b0);
    rchk(8'h60, 32'h0000_0440, RESP_OKAY);
    rchk(8'h60, 32'h0000_0400, RESP_OKAY);
    // Masked event keeps the line low
    wchk(8'h6C, 32'h0, RESP_OKAY);
    err_pulse(1);
    chk(irq, 1'b0);
    // Unmapped place is refused
    rchk(8'h70, 32'h0, RESP_SLVERR);
    wchk(8'h70, 32'h0000_1234, RESP_SLVERR);
    rchk(8'h54, 32'h1, RESP_OKAY);
    // Strap defaults after a second and a third reset
    restart(1'b1, 1'b0);
    rchk(8'h60, 32'h0000_0500, RESP_OKAY);
    rchk(8'h54, 32'h0, RESP_OKAY);
    restart(1'b0, 1'b0);
    rchk(8'h60, 32'h0000_0405, RESP_OKAY);
    wchk(8'h60, 32'h0000_0400, RESP_OKAY);
    rchk(8'h60, 32'h0000_0404, RESP_OKAY);
    tally_and_finish();
  end
endmodule // phy_mode_ctrl_rx_err_count_test

// *** logic/phy_mode_ctrl.sv ***
`timescale 1ns/100ps
`include "phy_mode_map.svh"

// Overview of operation
// - Sixteen-bit read/write receive error count, counts error events, resets to zero.
// - Full flag in mode bit 6 set while count full, cleared on read.
// - Mode bit 5 high stops counting receive errors.
// - Mode bit 14 forces link up at 10 Mbps; software disables autoneg first.
// - Mode bit 13 forces link up at 100 Mbps; software disables autoneg first.
// - Mode bit 12 high turns off jabber protection; reset value zero.
// - Mode bit 10 high makes activity receive-only; ignored in repeater mode.
// - Mode bit 8 stops far fault detect, and generate unless bit 7 forces it; default from fiber mode.
// - Mode bit 7 forces far fault pattern out regardless of detection.
// - Mode bit 4 high disables decoder watchdog timer.
// - Mode bit 3 high enables remote loopback; reset value zero.
// - Mode bit 2 enables scrambling; power-on default from scramble strap.
// - Scramble bit forced one when fiber strap low or fiber select high.
// - Mode bit 0 selects fiber or twisted pair; default from fiber strap.
// - Mode bit 15 picks internal or external signal detect common mode.

module phy_mode_ctrl (
  input wire logic sys_clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire phy_mode_pkg::bus_addr_t awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire phy_mode_pkg::bus_data_t wdata,
  input wire phy_mode_pkg::bus_strb_t wstrb,
  input wire logic wvalid,
  output logic wready,
  output phy_mode_pkg::bus_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  input wire phy_mode_pkg::bus_addr_t araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output phy_mode_pkg::bus_data_t rdata,
  output phy_mode_pkg::bus_resp_t rresp,
  output logic rvalid,
  input wire logic rready,
  // Pins and media-side status
  input wire logic rx_error_event,
  input wire logic fiber_strap_pin_n,
  input wire logic scramble_strap_pin,
  input wire logic repeater_mode,
  input wire logic nlp_link_ok,
  input wire logic link_ok_100,
  input wire logic local_fault_detected,
  input wire logic far_fault_pattern_seen,
  input wire logic rx_activity,
  input wire logic tx_activity,
  // Controls to the port datapath, and the interrupt request
  output logic signal_detect_common_mode_select,
  output logic link_up_10,
  output logic link_up_100,
  output logic jabber_protect_enable,
  output logic activity_indication,
  output logic far_fault_transmit,
  output logic far_fault_detected,
  output logic decoder_watchdog_disable,
  output logic remote_loopback_enable,
  output logic scramble_enable,
  output logic fiber_mode_select,
  output logic irq
);

  import phy_mode_pkg::*;

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic [9:0] pins_s;
  logic err_s, fiber_n_s, scram_s, rptr_s, nlp_s, l100_s;
  logic lfault_s, ffault_s, rxa_s, txa_s;

  pin_sync #(
    .WIDTH(10)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .async_in({tx_activity, rx_activity, far_fault_pattern_seen, local_fault_detected, link_ok_100,
               nlp_link_ok, repeater_mode, scramble_strap_pin, fiber_strap_pin_n, rx_error_event}),
    .sync_out(pins_s)
  );

  assign err_s = pins_s[0];
  assign fiber_n_s = pins_s[1];
  assign scram_s = pins_s[2];
  assign rptr_s = pins_s[3];
  assign nlp_s = pins_s[4];
  assign l100_s = pins_s[5];
  assign lfault_s = pins_s[6];
  assign ffault_s = pins_s[7];
  assign rxa_s = pins_s[8];
  assign txa_s = pins_s[9];

  // ****************************************************************
  // State
  // ****************************************************************
  logic strap_done_q;
  logic err_prev_q;
  reg16_t count_q, count_d;
  reg16_t mode_q, mode_d;
  logic full_q, full_d;
  logic [`IRQ_WIDTH-1:0] status_q, status_d, mask_q, mask_d;

  logic awready_q, awready_d, wready_q, wready_d;
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  bus_addr_t waddr_q;
  bus_data_t wdata_q;
  bus_strb_t wstrb_q;
  logic bvalid_q, bvalid_d;
  bus_resp_t bresp_q;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  bus_data_t rdata_q;
  bus_resp_t rresp_q;

  // ****************************************************************
  // Bus handshakes
  // ****************************************************************
  wire aw_take = awvalid & awready_q;
  wire w_take = wvalid & wready_q;
  wire ar_take = arvalid & arready_q;
  // Both halves held and no response pending: commit the write
  wire do_write = aw_full_q & w_full_q & ~bvalid_q;

  assign aw_full_d = do_write ? 1'b0 : (aw_full_q | aw_take);
  assign w_full_d = do_write ? 1'b0 : (w_full_q | w_take);
  assign bvalid_d = do_write | (bvalid_q & ~bready);
  // One write in flight: no new address or data until the response is taken
  assign awready_d = ~aw_full_d & ~bvalid_d;
  assign wready_d = ~w_full_d & ~bvalid_d;
  assign rvalid_d = ar_take | (rvalid_q & ~rready);
  assign arready_d = ~rvalid_d;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire [5:0] widx = waddr_q[7:2];
  wire [5:0] ridx = araddr[7:2];
  wire wr_count = do_write & (widx == `IDX_RX_ERR_COUNT);
  wire wr_mode = do_write & (widx == `IDX_PORT_MODE);
  wire wr_status = do_write & (widx == `IDX_IRQ_STATUS);
  wire wr_mask = do_write & (widx == `IDX_IRQ_MASK);
  wire wr_hit = wr_count | wr_mode | wr_status | wr_mask;
  wire rd_count = ridx == `IDX_RX_ERR_COUNT;
  wire rd_mode = ridx == `IDX_PORT_MODE;
  wire rd_status = ridx == `IDX_IRQ_STATUS;
  wire rd_mask = ridx == `IDX_IRQ_MASK;
  wire rd_hit = rd_count | rd_mode | rd_status | rd_mask;

  // Byte lanes 0 and 1 carry the 16-bit registers; upper lanes are ignored
  wire [15:0] lane_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [15:0] wval16 = wdata_q[15:0] & lane_mask;

  // ****************************************************************
  // Receive error counter
  // ****************************************************************
  wire err_event = err_s & ~err_prev_q;
  wire count_at_max = count_q == `COUNT_MAX;
  wire count_enable = ~mode_q[`MODE_CNT_DIS];
  wire count_step = err_event & count_enable & ~count_at_max;

  always_comb begin
    count_d = count_q;
    if (wr_count) begin
      count_d = (count_q & ~lane_mask) | wval16;
    end else if (count_step) begin
      count_d = count_q + 16'h0001;
    end
  end

  // Full flag, read clears but a full count sets it again
  assign full_d = count_at_max | (full_q & ~(ar_take & rd_mode));

  // ****************************************************************
  // Mode control register
  // ****************************************************************
  wire fiber_now = mode_q[`MODE_FIBER_SEL];

  always_comb begin
    mode_d = mode_q;
    if (!strap_done_q) begin
      // Fiber select from strap, low means fiber
      mode_d[`MODE_FIBER_SEL] = ~fiber_n_s;
      // Far fault disable defaults off only in fiber mode
      mode_d[`MODE_FAULT_DIS] = fiber_n_s;
      mode_d[`MODE_SCRAMBLE_EN] = scram_s;
    // Reserved bits and the full flag are never stored
    end else if (wr_mode) begin
      mode_d = ((mode_q & ~lane_mask) | wval16) & `MODE_WRITABLE;
    end
    if (!fiber_n_s || mode_d[`MODE_FIBER_SEL]) begin
      mode_d[`MODE_SCRAMBLE_EN] = 1'b1;
    end
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  wire [`IRQ_WIDTH-1:0] irq_set = {count_step, count_at_max};
  wire [`IRQ_WIDTH-1:0] irq_clr = wr_status ? wval16[`IRQ_WIDTH-1:0] : '0;
  // A new event in the clearing cycle is kept
  assign status_d = (status_q & ~irq_clr) | irq_set;
  assign mask_d = wr_mask ? ((mask_q & ~lane_mask[`IRQ_WIDTH-1:0]) | wval16[`IRQ_WIDTH-1:0]) : mask_q;

  // ****************************************************************
  // Read data
  // ****************************************************************
  reg16_t mode_view;
  always_comb begin
    mode_view = mode_q;
    mode_view[`MODE_CNT_FULL] = full_q;
  end

  wire [15:0] rd_word = rd_count ? count_q :
                        rd_mode ? mode_view :
                        rd_status ? {14'h0000, status_q} :
                        rd_mask ? {14'h0000, mask_q} : 16'h0000;

  // ****************************************************************
  // Port datapath controls
  // ****************************************************************
  // Forced 10 Mbps link skips pulse checking
  wire link10_d = mode_q[`MODE_FORCE_10] | nlp_s;
  wire link100_d = mode_q[`MODE_FORCE_100] | l100_s;
  wire act_rx_only = mode_q[`MODE_ACT_RX_ONLY] & ~rptr_s;
  wire activity_d = rxa_s | (txa_s & ~act_rx_only);
  wire fault_on = ~mode_q[`MODE_FAULT_DIS];
  wire fault_tx_d = mode_q[`MODE_FORCE_FAULT] | (fault_on & lfault_s);
  wire fault_rx_d = fault_on & ffault_s;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      err_prev_q <= 1'b0;
      count_q <= `COUNT_RESET;
      mode_q <= `MODE_RESET;
      full_q <= 1'b0;
      status_q <= '0;
      mask_q <= '0;
    end else begin
      strap_done_q <= 1'b1;
      err_prev_q <= err_s;
      count_q <= count_d;
      mode_q <= mode_d;
      full_q <= full_d;
      status_q <= status_d;
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      bvalid_q <= bvalid_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        waddr_q <= awaddr;
      end
      if (w_take) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_write) begin
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (ar_take) begin
        rdata_q <= {16'h0000, rd_word};
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Outputs lag the register by one cycle so every port leaves a flop
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      signal_detect_common_mode_select <= 1'b0;
      link_up_10 <= 1'b0;
      link_up_100 <= 1'b0;
      jabber_protect_enable <= 1'b1;
      activity_indication <= 1'b0;
      far_fault_transmit <= 1'b0;
      far_fault_detected <= 1'b0;
      decoder_watchdog_disable <= 1'b0;
      remote_loopback_enable <= 1'b0;
      scramble_enable <= 1'b0;
      fiber_mode_select <= 1'b0;
      irq <= 1'b0;
    end else begin
      signal_detect_common_mode_select <= mode_q[`MODE_SD_CM_SEL];
      link_up_10 <= link10_d;
      link_up_100 <= link100_d;
      jabber_protect_enable <= ~mode_q[`MODE_JABBER_DIS];
      activity_indication <= activity_d;
      far_fault_transmit <= fault_tx_d;
      far_fault_detected <= fault_rx_d;
      decoder_watchdog_disable <= mode_q[`MODE_WDT_DIS];
      remote_loopback_enable <= mode_q[`MODE_RLOOP_EN];
      scramble_enable <= mode_q[`MODE_SCRAMBLE_EN];
      fiber_mode_select <= fiber_now;
      irq <= |(status_q & mask_q);
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

endmodule // phy_mode_ctrl

// *** logic/phy_mode_map.svh ***
`ifndef PHY_MODE_MAP_SVH
`define PHY_MODE_MAP_SVH

// ****************************************************************
// Register word indices (byte address is index times four)
// ****************************************************************
`define IDX_RX_ERR_COUNT 6'h15
`define IDX_PORT_MODE 6'h18
`define IDX_IRQ_STATUS 6'h1A
`define IDX_IRQ_MASK 6'h1B

// ****************************************************************
// Mode control field positions
// ****************************************************************
`define MODE_SD_CM_SEL 15
`define MODE_FORCE_10 14
`define MODE_FORCE_100 13
`define MODE_JABBER_DIS 12
`define MODE_ACT_RX_ONLY 10
`define MODE_FAULT_DIS 8
`define MODE_FORCE_FAULT 7
`define MODE_CNT_FULL 6
`define MODE_CNT_DIS 5
`define MODE_WDT_DIS 4
`define MODE_RLOOP_EN 3
`define MODE_SCRAMBLE_EN 2
`define MODE_FIBER_SEL 0

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define MODE_RESET 16'h0400
`define MODE_WRITABLE 16'hF5BD
`define COUNT_RESET 16'h0000
`define COUNT_MAX 16'hFFFF

// ****************************************************************
// Interrupt status bit positions
// ****************************************************************
`define IRQ_COUNT_FULL 0
`define IRQ_RX_ERROR 1
`define IRQ_WIDTH 2

`endif

// *** logic/phy_mode_pkg.sv ***
package phy_mode_pkg;

  typedef logic [15:0] reg16_t;
  typedef logic [7:0] bus_addr_t;
  typedef logic [31:0] bus_data_t;
  typedef logic [3:0] bus_strb_t;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } bus_resp_t;

endpackage

// *** logic/pin_sync.sv ***
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // ****************************************************************
  // Two stages; only the second stage reads the first
  // No reset: the chain fills during reset, so straps are settled at release
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    meta_q <= async_in;
    sync_out <= meta_q;
  end

endmodule // pin_sync
